// >>> design/rcoc_pkg.sv
// Shared constants and types of the operand core
package rcoc_pkg;
  localparam int unsigned DW     = 16;
  localparam int unsigned RIDX_W = 4;
  localparam int unsigned NREG   = 16;

  typedef enum logic [3:0] {
    ST_FETCH    = 4'b0000,
    ST_DECODE   = 4'b0001,
    ST_SRC_EXT  = 4'b0010,
    ST_SRC_READ = 4'b0011,
    ST_DST_EXT  = 4'b0100,
    ST_DST_READ = 4'b0101,
    ST_EXEC     = 4'b0110,
    ST_IRQ_PC   = 4'b0111,
    ST_IRQ_SR   = 4'b1000,
    ST_POP_PC   = 4'b1001,
    ST_POP_END  = 4'b1010
  } rcoc_state_type;

  // Dedicated registers
  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;
  localparam logic [3:0] REG_SR = 4'h2;
  localparam logic [3:0] REG_CG = 4'h3;

  // Status register bit positions
  localparam int unsigned SR_C      = 0;
  localparam int unsigned SR_Z      = 1;
  localparam int unsigned SR_N      = 2;
  localparam int unsigned SR_GIE    = 3;
  localparam int unsigned SR_CPUOFF = 4;
  localparam int unsigned SR_OSCOFF = 5;
  localparam int unsigned SR_SCG0   = 6;
  localparam int unsigned SR_SCG1   = 7;
  localparam int unsigned SR_V      = 8;
  localparam logic [15:0] SR_ENTRY_CLEAR = 16'h00f8;

  // Instruction word layout
  localparam logic [2:0] FMT_JUMP_TAG   = 3'b001;
  localparam logic [5:0] FMT_SINGLE_TAG = 6'b000100;
  localparam logic [3:0] FMT_DUAL_MIN   = 4'h4;

  // Source addressing field
  localparam logic [1:0] SMODE_REGISTER = 2'b00;
  localparam logic [1:0] SMODE_INDEXED  = 2'b01;
  localparam logic [1:0] SMODE_AUTOINC  = 2'b11;

  // Operation codes, bit 4 set for the single-operand format
  localparam logic [4:0] OP_TRANSFER = 5'h04;
  localparam logic [4:0] OP_ADD  = 5'h05;
  localparam logic [4:0] OP_ADDC = 5'h06;
  localparam logic [4:0] OP_SUBC = 5'h07;
  localparam logic [4:0] OP_SUB  = 5'h08;
  localparam logic [4:0] OP_CMP  = 5'h09;
  localparam logic [4:0] OP_DADD = 5'h0a;
  localparam logic [4:0] OP_BIT  = 5'h0b;
  localparam logic [4:0] OP_BIC  = 5'h0c;
  localparam logic [4:0] OP_BIS  = 5'h0d;
  localparam logic [4:0] OP_XOR  = 5'h0e;
  localparam logic [4:0] OP_AND  = 5'h0f;
  localparam logic [4:0] OP_RRC  = 5'h10;
  localparam logic [4:0] OP_SWPB = 5'h11;
  localparam logic [4:0] OP_RRA  = 5'h12;
  localparam logic [4:0] OP_SXT  = 5'h13;
  localparam logic [4:0] OP_PUSH = 5'h14;
  localparam logic [4:0] OP_CALL = 5'h15;
  localparam logic [4:0] OP_RETI = 5'h16;

  // Jump conditions
  localparam logic [2:0] JC_BRANCH_IF_NOT_EQUAL = 3'h0;
  localparam logic [2:0] JC_EQUAL               = 3'h1;
  localparam logic [2:0] JC_NO_CARRY            = 3'h2;
  localparam logic [2:0] JC_CARRY               = 3'h3;
  localparam logic [2:0] JC_NEGATIVE           = 3'h4;
  localparam logic [2:0] JC_GREATER_EQUAL       = 3'h5;
  localparam logic [2:0] JC_LESS                = 3'h6;

  // Constant generator values
  localparam logic [15:0] CG_R2_IND  = 16'h0004;
  localparam logic [15:0] CG_R2_AUTO = 16'h0008;
  localparam logic [15:0] CG_R3_REG  = 16'h0000;
  localparam logic [15:0] CG_R3_IDX  = 16'h0001;
  localparam logic [15:0] CG_R3_IND  = 16'h0002;
  localparam logic [15:0] CG_R3_AUTO = 16'hffff;

  // Operating mode codes
  localparam logic [2:0] LP_FULL_RUN_STATE       = 3'h0;
  localparam logic [2:0] LP_LOW_POWER_LEVEL_ZERO = 3'h1;
  localparam logic [2:0] LP_LOW_POWER_LEVEL_ONE  = 3'h2;
  localparam logic [2:0] LP_LOW_POWER_LEVEL_TWO  = 3'h3;
  localparam logic [2:0] LP_LOW_POWER_LEVEL_THREE = 3'h4;
  localparam logic [2:0] LP_LOW_POWER_LEVEL_FOUR = 3'h5;

  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] RESET_PC  = 16'h0000;
  localparam logic [15:0] RESET_SR  = 16'h0000;
  localparam logic [15:0] RESET_REG = 16'h0000;
endpackage : rcoc_pkg

// >>> design/rcoc_regfile.sv
// General register storage with three read ports and one write port
`timescale 1ns/10ps
module rcoc_regfile (
  // Clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       arst_n_i,
  // Write port
  input  wire logic                       we_i,
  input  wire logic [rcoc_pkg::RIDX_W-1:0] widx_i,
  input  wire logic [rcoc_pkg::DW-1:0]     wdata_i,
  // Read ports
  input  wire logic [rcoc_pkg::RIDX_W-1:0] ridx_a_i,
  input  wire logic [rcoc_pkg::RIDX_W-1:0] ridx_b_i,
  output logic      [rcoc_pkg::DW-1:0]     rdata_a_o,
  output logic      [rcoc_pkg::DW-1:0]     rdata_b_o,
  output logic      [rcoc_pkg::DW-1:0]     rdata_sp_o
);
  import rcoc_pkg::*;

  logic [DW-1:0] store [NREG];
  logic [DW-1:0] next_store [NREG];

  // Reads come straight off the storage flops
  assign rdata_a_o  = store[ridx_a_i];
  assign rdata_b_o  = store[ridx_b_i];
  assign rdata_sp_o = store[REG_SP];

  always_comb begin
    next_store = store;
    if (we_i) begin
      next_store[widx_i] = wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NREG; i++) begin
        store[i] <= RESET_REG;
      end
    end else begin
      store <= next_store;
    end
  end
endmodule : rcoc_regfile

// >>> design/rcoc_core.sv
// What this block does
// - Sixteen registers of sixteen bits each
// - R0-R3 are PC, SP, SR, constants
// - Register to register operation takes one cycle
// - Non-flow instructions are register operations plus modes
// - Seven source and four destination addressing modes
// - Core instruction set in three formats
// - Word or byte operand size per instruction
// - Call pushes PC then loads operand
// - Not-equal jump taken when zero flag clear
// - Indirect, autoincrement, immediate are source only
// - Autoincrement reads then adds two for words
// - Peripherals reached as memory-mapped bus operands
// - Core halts in every low-power mode
// - Interrupt wakes; return restores previous low-power mode
`timescale 1ns/10ps
module rcoc_core (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  // Memory and peripheral bus
  output logic      [15:0] mem_addr_o,
  output logic      [15:0] mem_wdata_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic             mem_byte_o,
  input  wire logic [15:0] mem_rdata_i,
  // Interrupt request
  input  wire logic        irq_i,
  input  wire logic [15:0] irq_vector_i,
  output logic             irq_ack_o,
  // Operating mode
  output logic      [2:0]  lp_mode_o,
  output logic             cpu_halted_o
);
  import rcoc_pkg::*;

  rcoc_state_type state, next_state;
  logic [15:0] pc, next_pc, sr, next_sr, ir, next_ir;
  logic [15:0] src, next_src, dst, next_dst, saddr, next_saddr, daddr, next_daddr;
  logic        dmem, next_dmem, next_mem_rd, next_mem_wr, next_mem_byte, next_irq_ack;
  logic [15:0] next_mem_addr, next_mem_wdata;
  logic [2:0]  next_lp;
  logic        next_halted;
  logic [15:0] ins, rf_a, rf_b, rf_sp, rs_val, rd_val, srcv_direct, op_s, op_d;
  logic [15:0] sp_dec, jump_target, w_data, ea;
  logic [3:0]  f_rs, f_rd, w_idx;
  logic [4:0]  op;
  logic [21:0] alu;
  logic        is_jump, is_dual, is_single, is_push, is_reti, cg, src_direct, fast;
  logic        jump_ok, exec_now, w_en, rf_we, alu_rw;

  function automatic logic [15:0] reg_get(input logic [3:0] idx, input logic [15:0] raw,
                                          input logic [15:0] p, input logic [15:0] s);
    if (idx == REG_PC) reg_get = p;
    else if (idx == REG_SR) reg_get = s;
    else if (idx == REG_CG) reg_get = CG_R3_REG;
    else reg_get = raw;
  endfunction : reg_get

  // Byte operands sit in the low lane, picked by the address bit
  function automatic logic [15:0] lane(input logic [15:0] w, input logic a0, input logic bw);
    if (!bw) lane = w;
    else lane = {8'h00, (a0 ? w[15:8] : w[7:0])};
  endfunction : lane

  // Absolute mode reuses indexed mode on the status register as a zero base
  function automatic logic [15:0] base(input logic [3:0] idx, input logic [15:0] v);
    base = (idx == REG_SR) ? 16'h0000 : v;
  endfunction : base

  function automatic logic [21:0] rcoc_alu(input logic [4:0] o, input logic [15:0] s,
                                           input logic [15:0] d, input logic [15:0] st,
                                           input logic bw);
    logic [15:0] a, r, rb;
    logic [16:0] sum;
    logic [8:0]  sumb;
    logic        ci, c, v, z, n, fw, rw, cz, sub, keep_hi;
    sub = (o == OP_SUBC) || (o == OP_SUB) || (o == OP_CMP);
    ci = (o == OP_SUB || o == OP_CMP) ? 1'b1 : ((o == OP_ADD || o == OP_DADD) ? 1'b0 : st[SR_C]);
    a = sub ? ~s : s;
    sum = {1'b0, d} + {1'b0, a} + {16'h0000, ci};
    sumb = {1'b0, d[7:0]} + {1'b0, a[7:0]} + {8'h00, ci};
    r = sum[15:0];
    c = bw ? sumb[8] : sum[16];
    v = bw ? (a[7] == d[7]) && (sumb[7] != d[7]) : (a[15] == d[15]) && (sum[15] != d[15]);
    fw = 1'b1;
    rw = 1'b1;
    cz = 1'b0;
    keep_hi = 1'b0;
    case (o)
      OP_TRANSFER: begin r = s; fw = 1'b0; end
      OP_CMP:  rw = 1'b0;
      OP_BIT:  begin r = s & d; rw = 1'b0; cz = 1'b1; v = 1'b0; end
      OP_AND:  begin r = s & d; cz = 1'b1; v = 1'b0; end
      OP_BIC:  begin r = ~s & d; fw = 1'b0; end
      OP_BIS:  begin r = s | d; fw = 1'b0; end
      OP_XOR:  begin r = s ^ d; cz = 1'b1; v = bw ? s[7] & d[7] : s[15] & d[15]; end
      OP_RRC:  begin r = bw ? {8'h00, st[SR_C], d[7:1]} : {st[SR_C], d[15:1]}; c = d[0]; v = 1'b0; end
      OP_RRA:  begin r = bw ? {8'h00, d[7], d[7:1]} : {d[15], d[15:1]}; c = d[0]; v = 1'b0; end
      OP_SWPB: begin r = {d[7:0], d[15:8]}; fw = 1'b0; keep_hi = 1'b1; end
      OP_SXT:  begin r = {{8{d[7]}}, d[7:0]}; cz = 1'b1; v = 1'b0; keep_hi = 1'b1; end
      default: ;
    endcase
    rb = (bw && !keep_hi) ? {8'h00, r[7:0]} : r;
    z = (bw && !keep_hi) ? (rb[7:0] == 8'h00) : (rb == 16'h0000);
    n = (bw && !keep_hi) ? rb[7] : rb[15];
    if (cz) c = ~z;
    rcoc_alu = {fw, v, n, z, c, rw, rb};
  endfunction : rcoc_alu

  function automatic logic [2:0] lp_level(input logic [15:0] s);
    if (!s[SR_CPUOFF]) lp_level = LP_FULL_RUN_STATE;
    else if (s[SR_OSCOFF]) lp_level = LP_LOW_POWER_LEVEL_FOUR;
    else if (s[SR_SCG1] && s[SR_SCG0]) lp_level = LP_LOW_POWER_LEVEL_THREE;
    else if (s[SR_SCG1]) lp_level = LP_LOW_POWER_LEVEL_TWO;
    else if (s[SR_SCG0]) lp_level = LP_LOW_POWER_LEVEL_ONE;
    else lp_level = LP_LOW_POWER_LEVEL_ZERO;
  endfunction : lp_level

  rcoc_regfile u_regfile (
    .sys_clk_i  (sys_clk_i),
    .arst_n_i   (arst_n_i),
    .we_i       (rf_we),
    .widx_i     (w_idx),
    .wdata_i    (w_data),
    .ridx_a_i   (f_rs),
    .ridx_b_i   (f_rd),
    .rdata_a_o  (rf_a),
    .rdata_b_o  (rf_b),
    .rdata_sp_o (rf_sp)
  );

  // Instruction decode, live from the bus in the decode cycle
  always_comb begin
    ins = (state == ST_DECODE) ? mem_rdata_i : ir;
    is_jump = ins[15:13] == FMT_JUMP_TAG;
    is_dual = ins[15:12] >= FMT_DUAL_MIN;
    is_single = ins[15:10] == FMT_SINGLE_TAG;
    f_rs = is_dual ? ins[11:8] : ins[3:0];
    f_rd = ins[3:0];
    op = is_dual ? {1'b0, ins[15:12]} : {2'b10, ins[9:7]};
    is_push = is_single && (op == OP_PUSH || op == OP_CALL);
    is_reti = is_single && op == OP_RETI;
    rs_val = reg_get(f_rs, rf_a, pc, sr);
    rd_val = reg_get(f_rd, rf_b, pc, sr);
    cg = (f_rs == REG_CG) || (f_rs == REG_SR && ins[5]);
    case ({f_rs == REG_CG, ins[5:4]})
      3'b100:  srcv_direct = CG_R3_REG;
      3'b101:  srcv_direct = CG_R3_IDX;
      3'b110:  srcv_direct = CG_R3_IND;
      3'b111:  srcv_direct = CG_R3_AUTO;
      3'b010:  srcv_direct = CG_R2_IND;
      3'b011:  srcv_direct = CG_R2_AUTO;
      default: srcv_direct = rs_val;
    endcase
    src_direct = cg || ins[5:4] == SMODE_REGISTER;
    fast = (is_dual && src_direct && !ins[7]) ||
           (is_single && src_direct && !is_push && !is_reti);
    case (ins[12:10])
      JC_BRANCH_IF_NOT_EQUAL: jump_ok = !sr[SR_Z];
      JC_EQUAL:               jump_ok = sr[SR_Z];
      JC_NO_CARRY:            jump_ok = !sr[SR_C];
      JC_CARRY:               jump_ok = sr[SR_C];
      JC_NEGATIVE:            jump_ok = sr[SR_N];
      JC_GREATER_EQUAL:       jump_ok = !(sr[SR_N] ^ sr[SR_V]);
      JC_LESS:                jump_ok = sr[SR_N] ^ sr[SR_V];
      default:                jump_ok = 1'b1;
    endcase
    jump_target = pc + {{5{ins[9]}}, ins[9:0], 1'b0};
    sp_dec = rf_sp - WORD_STEP;
    op_s = (state == ST_EXEC) ? src : srcv_direct;
    op_d = (state == ST_EXEC) ? dst : (is_dual ? rd_val : srcv_direct);
    alu = rcoc_alu(op, op_s, op_d, sr, ins[6]);
    alu_rw = alu[16];
  end

  always_comb begin
    next_state = state;
    next_pc = pc;
    next_sr = sr;
    next_ir = ir;
    next_src = src;
    next_dst = dst;
    next_saddr = saddr;
    next_daddr = daddr;
    next_dmem = dmem;
    next_mem_rd = 1'b0;
    next_mem_wr = 1'b0;
    next_mem_byte = 1'b0;
    next_mem_addr = mem_addr_o;
    next_mem_wdata = mem_wdata_o;
    next_irq_ack = 1'b0;
    exec_now = 1'b0;
    w_en = 1'b0;
    w_idx = REG_CG;
    w_data = 16'h0000;
    ea = 16'h0000;
    rf_we = 1'b0;
    case (state)
      ST_FETCH: begin
        if (irq_i && sr[SR_GIE]) begin
          next_state = ST_IRQ_PC;
        end else if (!sr[SR_CPUOFF]) begin
          next_mem_rd = 1'b1;
          next_mem_addr = pc;
          next_pc = pc + WORD_STEP;
          next_state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        next_ir = mem_rdata_i;
        next_state = ST_FETCH;
        if (is_jump) begin
          if (jump_ok) next_pc = jump_target;
        end else if (is_reti) begin
          next_mem_rd = 1'b1;
          next_mem_addr = rf_sp;
          {w_en, w_idx, w_data} = {1'b1, REG_SP, rf_sp + WORD_STEP};
          next_state = ST_POP_PC;
        end else if (fast) begin
          exec_now = 1'b1;
        end else if (!src_direct && ins[5:4] == SMODE_INDEXED) begin
          next_mem_rd = 1'b1;
          next_mem_addr = pc;
          next_pc = pc + WORD_STEP;
          next_state = ST_SRC_EXT;
        end else if (!src_direct) begin
          next_mem_rd = 1'b1;
          next_mem_addr = rs_val;
          next_saddr = rs_val;
          if (ins[5:4] == SMODE_AUTOINC) begin
            w_en = 1'b1;
            w_idx = f_rs;
            w_data = rs_val + ((ins[6] && f_rs != REG_PC) ? BYTE_STEP : WORD_STEP);
          end
          next_state = ST_SRC_READ;
        end else if (is_dual) begin
          next_src = srcv_direct;
          next_mem_rd = 1'b1;
          next_mem_addr = pc;
          next_pc = pc + WORD_STEP;
          next_state = ST_DST_EXT;
        end else begin
          next_src = srcv_direct;
          next_dmem = 1'b0;
          next_state = ST_EXEC;
        end
      end
      ST_SRC_EXT: begin
        ea = mem_rdata_i + base(f_rs, rs_val);
        next_mem_rd = 1'b1;
        next_mem_addr = ea;
        next_saddr = ea;
        next_state = ST_SRC_READ;
      end
      ST_SRC_READ: begin
        next_src = lane(mem_rdata_i, saddr[0], ins[6]);
        next_state = ST_EXEC;
        if (is_single) begin
          next_dst = lane(mem_rdata_i, saddr[0], ins[6]);
          next_daddr = saddr;
          next_dmem = !is_push;
        end else if (ins[7]) begin
          next_mem_rd = 1'b1;
          next_mem_addr = pc;
          next_pc = pc + WORD_STEP;
          next_state = ST_DST_EXT;
        end else begin
          next_dst = rd_val;
          next_dmem = 1'b0;
        end
      end
      ST_DST_EXT: begin
        ea = mem_rdata_i + base(f_rd, rd_val);
        next_mem_rd = 1'b1;
        next_mem_addr = ea;
        next_daddr = ea;
        next_dmem = 1'b1;
        next_state = ST_DST_READ;
      end
      ST_DST_READ: begin
        next_dst = lane(mem_rdata_i, daddr[0], ins[6]);
        next_state = ST_EXEC;
      end
      ST_EXEC: begin
        exec_now = 1'b1;
        next_state = ST_FETCH;
      end
      ST_IRQ_PC: begin
        {next_mem_wr, next_mem_addr, next_mem_wdata} = {1'b1, sp_dec, pc};
        {w_en, w_idx, w_data} = {1'b1, REG_SP, sp_dec};
        next_state = ST_IRQ_SR;
      end
      ST_IRQ_SR: begin
        // Saved status keeps the sleep bits so the return restores them
        {next_mem_wr, next_mem_addr, next_mem_wdata} = {1'b1, sp_dec, sr};
        {w_en, w_idx, w_data} = {1'b1, REG_SP, sp_dec};
        next_sr = sr & ~SR_ENTRY_CLEAR;
        next_pc = irq_vector_i;
        next_irq_ack = 1'b1;
        next_state = ST_FETCH;
      end
      ST_POP_PC: begin
        next_sr = mem_rdata_i;
        next_mem_rd = 1'b1;
        next_mem_addr = rf_sp;
        {w_en, w_idx, w_data} = {1'b1, REG_SP, rf_sp + WORD_STEP};
        next_state = ST_POP_END;
      end
      ST_POP_END: begin
        next_pc = mem_rdata_i;
        next_state = ST_FETCH;
      end
      default: next_state = ST_FETCH;
    endcase
    if (exec_now) begin
      if (is_push) begin
        next_mem_wr = 1'b1;
        next_mem_addr = sp_dec;
        next_mem_wdata = (op == OP_CALL) ? pc : op_s;
        {w_en, w_idx, w_data} = {1'b1, REG_SP, sp_dec};
        if (op == OP_CALL) next_pc = op_s;
      end else begin
        if (alu[21]) next_sr = {sr[15:9], alu[20], sr[7:3], alu[19], alu[18], alu[17]};
        if (alu_rw && state == ST_EXEC && dmem) begin
          next_mem_wr = 1'b1;
          next_mem_addr = daddr;
          next_mem_byte = ins[6];
          next_mem_wdata = ins[6] ? {alu[7:0], alu[7:0]} : alu[15:0];
        end else if (alu_rw) begin
          {w_en, w_idx, w_data} = {1'b1, (is_dual ? f_rd : f_rs), alu[15:0]};
        end
      end
    end
    if (w_en) begin
      if (w_idx == REG_PC) next_pc = w_data;
      else if (w_idx == REG_SR) next_sr = w_data;
      else if (w_idx != REG_CG) rf_we = 1'b1;
    end
    next_lp = lp_level(next_sr);
    next_halted = (next_state == ST_FETCH) && next_sr[SR_CPUOFF];
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_FETCH;
      {pc, sr, ir, src, dst, saddr, daddr} <= {RESET_PC, RESET_SR, 80'h0};
      {dmem, mem_rd_o, mem_wr_o, mem_byte_o, irq_ack_o, cpu_halted_o} <= 6'h00;
      {mem_addr_o, mem_wdata_o} <= 32'h0000_0000;
      lp_mode_o <= LP_FULL_RUN_STATE;
    end else begin
      state <= next_state;
      {pc, sr, ir, src, dst, saddr, daddr} <=
        {next_pc, next_sr, next_ir, next_src, next_dst, next_saddr, next_daddr};
      {dmem, mem_rd_o, mem_wr_o, mem_byte_o, irq_ack_o, cpu_halted_o} <=
        {next_dmem, next_mem_rd, next_mem_wr, next_mem_byte, next_irq_ack, next_halted};
      {mem_addr_o, mem_wdata_o} <= {next_mem_addr, next_mem_wdata};
      lp_mode_o <= next_lp;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_sleep_irq;
    state == ST_FETCH && sr[SR_CPUOFF] && irq_i && sr[SR_GIE];
  endsequence
  sequence s_irq_entry;
    state == ST_IRQ_PC ##1 state == ST_IRQ_SR ##1 (irq_ack_o && state == ST_FETCH);
  endsequence

  AST_REG_ONE_CYCLE: assert property (state == ST_DECODE && fast |=> state == ST_FETCH)
    else $error("register operation took more than one cycle");
  AST_SLEEP_HALT: assert property (state == ST_FETCH && sr[SR_CPUOFF] && !(irq_i && sr[SR_GIE])
    |=> !mem_rd_o && state == ST_FETCH && cpu_halted_o)
    else $error("core fetched while in a low-power mode");
  AST_IRQ_WAKE: assert property (s_sleep_irq |=> s_irq_entry)
    else $error("interrupt did not wake the core");
  AST_RETI_RESTORE: assert property (state == ST_POP_PC |=> sr == $past(mem_rdata_i))
    else $error("return did not restore the status register");
  AST_CALL_PUSH: assert property (exec_now && op == OP_CALL && is_single
    |=> mem_wr_o && mem_addr_o == $past(sp_dec) && mem_wdata_o == $past(pc)
        && pc == $past(op_s))
    else $error("call did not push the program counter");
  AST_NOT_EQUAL_HOLD: assert property (state == ST_DECODE && is_jump
    && ins[12:10] == JC_BRANCH_IF_NOT_EQUAL && sr[SR_Z] |=> pc == $past(pc))
    else $error("not-equal jump taken with zero set");
  AST_NOT_EQUAL_TAKE: assert property (state == ST_DECODE && is_jump
    && ins[12:10] == JC_BRANCH_IF_NOT_EQUAL && !sr[SR_Z] |=> pc == $past(jump_target))
    else $error("not-equal jump not taken with zero clear");
  AST_AUTOINC_READ: assert property (state == ST_DECODE && !is_jump && !is_reti && !fast
    && !cg && ins[5:4] == SMODE_AUTOINC |=> state == ST_SRC_READ && mem_rd_o
    && mem_addr_o == $past(rs_val))
    else $error("autoincrement did not read through the register");
  AST_DST_WRITEBACK: assert property (state == ST_EXEC && dmem && !is_push && alu_rw
    |=> mem_wr_o && mem_addr_o == $past(daddr) && mem_byte_o == $past(ins[6]))
    else $error("result not written to destination");
endmodule : rcoc_core

// >>> sim/rcoc_mem_model.sv
// Zero-wait memory and peripheral space on the far side of the core bus
`timescale 1ns/10ps
module rcoc_mem_model (
  // Clock
  input  wire logic        sys_clk_i,
  // Core bus
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [15:0] mem_wdata_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic        mem_byte_i,
  output logic      [15:0] mem_rdata_o
);
  logic [15:0] mem [0:255];

  // Outside a read the lines carry the inverted address, so a stray sample never matches
  assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i[8:1]] : ~mem_addr_i;

  // Byte writes arrive on both lanes; address bit 0 picks the lane
  always @(posedge sys_clk_i) begin
    if (mem_wr_i && !mem_byte_i) begin
      mem[mem_addr_i[8:1]] <= mem_wdata_i;
    end else if (mem_wr_i && mem_addr_i[0]) begin
      mem[mem_addr_i[8:1]][15:8] <= mem_wdata_i[15:8];
    end else if (mem_wr_i) begin
      mem[mem_addr_i[8:1]][7:0] <= mem_wdata_i[7:0];
    end
  end
endmodule : rcoc_mem_model

// >>> sim/testbench.sv
// Self-checking bench running small programs on the core
`timescale 1ns/10ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
  fail_count++; $display("Error %s expected %h seen %h", what, exp, got); end end
module testbench;
  import rcoc_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic        mem_rd_o, mem_wr_o, mem_byte_o, irq_ack_o, cpu_halted_o;
  logic        irq_i = 1'b0;
  logic [15:0] irq_vector_i = 16'h0000;
  logic [2:0]  lp_mode_o;
  int          fail_count = 0;
  int          samples_checked = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  rcoc_core rcoc_core_inst (.sys_clk_i, .arst_n_i, .mem_addr_o, .mem_wdata_o, .mem_rd_o,
    .mem_wr_o, .mem_byte_o, .mem_rdata_i, .irq_i, .irq_vector_i, .irq_ack_o, .lp_mode_o,
    .cpu_halted_o);
  rcoc_mem_model rcoc_mem_model_inst (.sys_clk_i(sys_clk_i), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_byte_i(mem_byte_o), .mem_rdata_o(mem_rdata_i));

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : step
  function automatic logic [15:0] rd(input logic [15:0] a);
    return rcoc_mem_model_inst.mem[a[8:1]];
  endfunction : rd
  task automatic poke(input logic [15:0] a, input logic [15:0] d);
    rcoc_mem_model_inst.mem[a[8:1]] = d;
  endtask : poke
  // Reset is held while the image is loaded, so the core never fetches a half-written program
  task automatic load(input logic [15:0] w[$]);
    arst_n_i = 1'b0;
    for (int i = 0; i < 256; i++) rcoc_mem_model_inst.mem[i] = 16'hffff;
    foreach (w[i]) rcoc_mem_model_inst.mem[i] = w[i];
  endtask : load
  task automatic go(input int n);
    step(12);
    arst_n_i = 1'b1;
    step(n);
  endtask : go

  task automatic test_add;
    load({16'h4034, 16'h1234, 16'h4035, 16'h0005, 16'h5405, 16'h4582, 16'h0100, 16'h3fff});
    go(60);
    `CHK("sum", 16'h1239, rd(16'h0100))
    $display("test_add done");
  endtask : test_add

  task automatic test_autoinc;
    load({16'h4036, 16'h0100, 16'h4637, 16'h4678, 16'h4782, 16'h0110, 16'h4882, 16'h0114,
          16'h4682, 16'h0112, 16'h48c2, 16'h0117, 16'h4292, 16'h0102, 16'h0118, 16'h3fff});
    poke(16'h0100, 16'habcd);
    poke(16'h0102, 16'h5a3c);
    go(80);
    `CHK("word", 16'habcd, rd(16'h0110))
    `CHK("byte", 16'h003c, rd(16'h0114))
    `CHK("pointer", 16'h0103, rd(16'h0112))
    `CHK("high lane", 16'h3cff, rd(16'h0116))
    `CHK("absolute copy", 16'h5a3c, rd(16'h0118))
    $display("test_autoinc done");
  endtask : test_autoinc

  task automatic test_call;
    load({16'h4031, 16'h0200, 16'h4038, 16'h0040, 16'h1288, 16'h3fff});
    poke(16'h0040, 16'h4882);
    poke(16'h0042, 16'h0120);
    poke(16'h0044, 16'h3fff);
    go(60);
    `CHK("pushed pc", 16'h000a, rd(16'h01fe))
    `CHK("callee ran", 16'h0040, rd(16'h0120))
    $display("test_call done");
  endtask : test_call

  task automatic test_jump;
    load({16'h4035, 16'h0001, 16'h8404, 16'h2002, 16'h4582, 16'h0130, 16'h9305, 16'h2002,
          16'h4582, 16'h0132, 16'h3fff});
    go(60);
    `CHK("not taken", 16'h0001, rd(16'h0130))
    `CHK("taken", 16'hffff, rd(16'h0132))
    $display("test_jump done");
  endtask : test_jump

  task automatic test_sleep;
    int k;
    load({16'h4031, 16'h0200, 16'hd032, 16'h0018, 16'h3fff});
    poke(16'h0080, 16'h40b2);
    poke(16'h0082, 16'h5a5a);
    poke(16'h0084, 16'h0140);
    poke(16'h0086, 16'h1300);
    go(40);
    `CHK("halted", 1'b1, cpu_halted_o)
    `CHK("mode", LP_LOW_POWER_LEVEL_ZERO, lp_mode_o)
    irq_vector_i = 16'h0080;
    irq_i = 1'b1;
    for (k = 0; k < 50 && irq_ack_o !== 1'b1; k++) step(1);
    `CHK("ack", 1'b1, irq_ack_o)
    irq_i = 1'b0;
    step(40);
    `CHK("handler", 16'h5a5a, rd(16'h0140))
    `CHK("asleep again", 1'b1, cpu_halted_o)
    `CHK("mode again", LP_LOW_POWER_LEVEL_ZERO, lp_mode_o)
    $display("test_sleep done");
  endtask : test_sleep

  // Deepest sleep with interrupts masked: a request must neither wake nor push
  task automatic test_deep_sleep;
    load({16'h4032, 16'h00f0, 16'h3fff});
    go(30);
    `CHK("deep halted", 1'b1, cpu_halted_o)
    `CHK("deep mode", LP_LOW_POWER_LEVEL_FOUR, lp_mode_o)
    irq_vector_i = 16'h0080;
    irq_i = 1'b1;
    step(20);
    `CHK("masked asleep", 1'b1, cpu_halted_o)
    `CHK("masked no push", 16'hffff, rd(16'h01fe))
    irq_i = 1'b0;
    $display("test_deep_sleep done");
  endtask : test_deep_sleep

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    test_add;
    test_autoinc;
    test_call;
    test_jump;
    test_sleep;
    test_deep_sleep;
    print_verdict;
  end
  // Tests need about 470 cycles; the limit leaves ample room
  initial begin
    #80000;
    fail_count++;
    print_verdict;
  end
endmodule : testbench
